// file: rtl/sfm_blink.sv
`timescale 1ns/1ps
module sfm_blink #(
  parameter int ON_CYC = sfm_pkg::BLINK_ON_CYC,
  parameter int OFF_CYC = sfm_pkg::BLINK_OFF_CYC,
  parameter int GAP_CYC = sfm_pkg::BLINK_GAP_CYC
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  sfm_blink_if.gen blink
);

  if (ON_CYC < 1 || OFF_CYC < 1 || GAP_CYC < 1)
  begin : g_chk
    $error("blink times must be at least one cycle");
  end

  typedef enum logic [3:0] {
    SFM_BL_IDLE = 4'h1,
    SFM_BL_ON = 4'h2,
    SFM_BL_OFF = 4'h4,
    SFM_BL_GAP = 4'h8
  } sfm_bl_state_t;

  typedef struct packed {
    sfm_bl_state_t state;
    logic [sfm_pkg::CNT_W-1:0] cnt;
    logic [4:0] left;
    logic led;
  } sfm_bl_t;

  sfm_bl_t cur_ff;
  sfm_bl_t nxt_cur;

  localparam logic [31:0] ON_LAST = 32'(ON_CYC - 1);
  localparam logic [31:0] OFF_LAST = 32'(OFF_CYC - 1);
  localparam logic [31:0] GAP_LAST = 32'(GAP_CYC - 1);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // code is sampled only between sequences so a count is never cut short
  always_comb
  begin
    nxt_cur = cur_ff;
    if (cur_ff.cnt != 32'h0)
    begin
      nxt_cur.cnt = cur_ff.cnt - 32'h1;
    end
    unique case (cur_ff.state)
      SFM_BL_IDLE:
      begin
        if (blink.code != sfm_pkg::CODE_NONE)
        begin
          nxt_cur.state = SFM_BL_ON;
          nxt_cur.left = blink.code;
          nxt_cur.cnt = ON_LAST;
          nxt_cur.led = 1'b1;
        end
      end
      SFM_BL_ON:
      begin
        if (cur_ff.cnt == 32'h0)
        begin
          nxt_cur.led = 1'b0;
          nxt_cur.left = cur_ff.left - 5'h01;
          if (cur_ff.left == 5'h01)
          begin
            nxt_cur.state = SFM_BL_GAP;
            nxt_cur.cnt = GAP_LAST;
          end
          else
          begin
            nxt_cur.state = SFM_BL_OFF;
            nxt_cur.cnt = OFF_LAST;
          end
        end
      end
      SFM_BL_OFF:
      begin
        if (cur_ff.cnt == 32'h0)
        begin
          nxt_cur.state = SFM_BL_ON;
          nxt_cur.cnt = ON_LAST;
          nxt_cur.led = 1'b1;
        end
      end
      SFM_BL_GAP:
      begin
        if (cur_ff.cnt == 32'h0)
        begin
          nxt_cur.state = SFM_BL_IDLE;
        end
      end
      default:
      begin
        nxt_cur.state = SFM_BL_IDLE;
        nxt_cur.led = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cur_ff <= '{state: SFM_BL_IDLE, cnt: '0, left: 5'h00, led: 1'b0};
    end
    else
    begin
      cur_ff <= nxt_cur;
    end
  end

  assign blink.led = cur_ff.led;
  assign blink.busy = (cur_ff.state != SFM_BL_IDLE);

endmodule : sfm_blink

// file: rtl/sfm_blink_if.sv
`timescale 1ns/1ps
interface sfm_blink_if;
  logic [4:0] code;
  logic led;
  logic busy;
  modport mgr (output code, input led, input busy);
  modport gen (input code, output led, output busy);
endinterface : sfm_blink_if

// file: rtl/sfm_fault_mgr.sv
`timescale 1ns/1ps
module sfm_fault_mgr #(
  parameter int FE_W = 16,
  parameter int HOLDOFF_CYC = sfm_pkg::HOLDOFF_CYC,
  parameter int BLINK_ON_CYC = sfm_pkg::BLINK_ON_CYC,
  parameter int BLINK_OFF_CYC = sfm_pkg::BLINK_OFF_CYC,
  parameter int BLINK_GAP_CYC = sfm_pkg::BLINK_GAP_CYC
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [19:0] fault_det_in,
  input wire logic bus_ov_above_in,
  input wire logic bus_ov_below_hyst_in,
  input wire logic enable_n_in,
  input wire logic aux_feedback_fault_in,
  input wire logic controller_sync_loss_in,
  input wire logic step_size_overflow_in,
  input wire logic signed [FE_W-1:0] following_error_in,
  output logic power_stage_en_out,
  output logic fault_active_out,
  output logic [4:0] fault_code_out,
  output logic [1:0] extended_fault_code_out,
  output logic [19:0] latched_faults_out,
  output logic status_led_out
);

  // ----------------------------------------------------------------
  // build-time checks
  // ----------------------------------------------------------------
  if (FE_W < 9)
  begin : g_chk
    $error("following error must hold 128");
  end

  if (HOLDOFF_CYC < 1)
  begin : g_chk_hold
    $error("holdoff must be at least one cycle");
  end

  // the pin vector is packed by hand from the ports above
  if (sfm_pkg::PIN_W != 25)
  begin : g_chk_pins
    $error("pin vector width does not match the port list");
  end

  if (sfm_pkg::NUM_CODES != 20)
  begin : g_chk_codes
    $error("code count does not match the fault input width");
  end

  // over- and under-voltage clear themselves and must never latch
  if (sfm_pkg::LATCH_CLASS[6] || sfm_pkg::LATCH_CLASS[7])
  begin : g_chk_class
    $error("self-resetting codes marked as latched");
  end

  if (BLINK_ON_CYC < 1 || BLINK_OFF_CYC < 1 || BLINK_GAP_CYC < 1)
  begin : g_chk_blink
    $error("blink times must be at least one cycle");
  end

  // a code listed twice would hide another one from the display
  for (genvar a = 0; a < sfm_pkg::NUM_CODES; a++)
  begin : g_prio_a
    for (genvar b = a + 1; b < sfm_pkg::NUM_CODES; b++)
    begin : g_prio_b
      if (sfm_pkg::PRIO_ORDER[a] == sfm_pkg::PRIO_ORDER[b])
      begin : g_dup
        $error("priority table lists a code twice");
      end
    end
  end

  for (genvar c = 0; c < sfm_pkg::NUM_CODES; c++)
  begin : g_prio_c
    if (sfm_pkg::PRIO_ORDER[c] == sfm_pkg::CODE_NONE ||
        sfm_pkg::PRIO_ORDER[c] > 5'(sfm_pkg::NUM_CODES))
    begin : g_range
      $error("priority table holds a code outside the code range");
    end
  end

  localparam int PW = sfm_pkg::PIN_W;
  localparam logic [31:0] HOLD_LAST = 32'(HOLDOFF_CYC - 1);
  localparam logic signed [FE_W-1:0] FE_POS =
    FE_W'(sfm_pkg::FE_LIMIT_REVS);
  localparam logic signed [FE_W-1:0] FE_NEG =
    FE_W'(-sfm_pkg::FE_LIMIT_REVS);
  localparam logic [19:0] SELF_CLASS = ~sfm_pkg::LATCH_CLASS;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [PW-1:0] s1;
    logic [PW-1:0] s2;
    logic [PW-1:0] s3;
    logic [PW-1:0] filt;
    logic ov;
    logic [19:0] latched;
    logic [31:0] hold;
    logic power_en;
    logic [4:0] shown;
    sfm_pkg::sfm_ext_t ext;
  } sfm_mgr_t;

  sfm_mgr_t cur_ff;
  sfm_mgr_t nxt_cur;

  logic [PW-1:0] pins;
  logic [19:0] present;
  logic [19:0] active;
  logic [19:0] self_now;
  logic clear_req;
  logic fe_ovf;
  logic opt_card;
  logic [4:0] best;
  logic shown_gone;
  logic shown_self;
  logic ext_event;
  sfm_pkg::sfm_ext_t ext_src;

  sfm_blink_if blink_bus ();

  assign pins = {controller_sync_loss_in, aux_feedback_fault_in,
                 enable_n_in, bus_ov_below_hyst_in, bus_ov_above_in,
                 fault_det_in};

  function automatic logic code_bit(input logic [19:0] vec,
                                    input logic [4:0] code);
    logic [4:0] idx;
    idx = code - sfm_pkg::CODE_ONE;
    code_bit = (code != sfm_pkg::CODE_NONE) && vec[idx];
  endfunction : code_bit

  // ----------------------------------------------------------------
  // fault collection
  // ----------------------------------------------------------------
  always_comb
  begin
    fe_ovf = (following_error_in > FE_POS) ||
             (following_error_in < FE_NEG);
    opt_card = cur_ff.filt[sfm_pkg::PIN_AUX_FB] ||
               cur_ff.filt[sfm_pkg::PIN_SYNC_LOSS];
    present = cur_ff.filt[19:0];
    // over-voltage follows the hysteresis latch, not the raw comparator
    present[sfm_pkg::CODE_OVERVOLT - sfm_pkg::CODE_ONE] = cur_ff.ov;
    present[sfm_pkg::CODE_POS_ERR - sfm_pkg::CODE_ONE] =
      cur_ff.filt[sfm_pkg::CODE_POS_ERR - sfm_pkg::CODE_ONE] ||
      step_size_overflow_in || fe_ovf;
    present[sfm_pkg::CODE_OPT_CARD - sfm_pkg::CODE_ONE] =
      cur_ff.filt[sfm_pkg::CODE_OPT_CARD - sfm_pkg::CODE_ONE] ||
      opt_card;
    clear_req = cur_ff.filt[sfm_pkg::PIN_ENABLE_N];
    self_now = present & SELF_CLASS;
    active = cur_ff.latched | self_now;
  end

  // ----------------------------------------------------------------
  // extended fault code source
  // ----------------------------------------------------------------
  // step overflow outranks following error, which outranks aux feedback;
  // sync loss gives no event, so the code keeps its last value
  always_comb
  begin
    ext_event = 1'b1;
    ext_src = sfm_pkg::SFM_EXT_NONE;
    if (step_size_overflow_in)
    begin
      ext_src = sfm_pkg::SFM_EXT_STEP_OVF;
    end
    else if (fe_ovf)
    begin
      ext_src = sfm_pkg::SFM_EXT_POS_OVF;
    end
    else if (cur_ff.filt[sfm_pkg::PIN_AUX_FB])
    begin
      ext_src = sfm_pkg::SFM_EXT_AUX_FB;
    end
    else
    begin
      ext_event = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // priority pick
  // ----------------------------------------------------------------
  always_comb
  begin
    best = sfm_pkg::CODE_NONE;
    for (int i = sfm_pkg::NUM_CODES - 1; i >= 0; i--)
    begin
      if (code_bit(active, sfm_pkg::PRIO_ORDER[i]))
      begin
        best = sfm_pkg::PRIO_ORDER[i];
      end
    end
    shown_gone = !code_bit(active, cur_ff.shown);
    shown_self = code_bit(SELF_CLASS, cur_ff.shown);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_cur = cur_ff;
    // three stages; a change counts once stages two and three agree
    nxt_cur.s1 = pins;
    nxt_cur.s2 = cur_ff.s1;
    nxt_cur.s3 = cur_ff.s2;
    nxt_cur.filt = (cur_ff.s2 & cur_ff.s3) |
                   (cur_ff.filt & (cur_ff.s2 | cur_ff.s3));

    if (cur_ff.filt[sfm_pkg::PIN_OV_ABOVE])
    begin
      nxt_cur.ov = 1'b1;
    end
    else if (cur_ff.filt[sfm_pkg::PIN_OV_BELOW])
    begin
      nxt_cur.ov = 1'b0;
    end

    // set wins over clear, so a fault still present while the
    // enable input is in disable stays latched
    nxt_cur.latched = (cur_ff.latched & {20{~clear_req}}) |
                      (present & sfm_pkg::LATCH_CLASS);

    if (self_now != 20'h0)
    begin
      nxt_cur.hold = HOLD_LAST;
    end
    else if (cur_ff.hold != 32'h0)
    begin
      nxt_cur.hold = cur_ff.hold - 32'h1;
    end

    // no external reset is needed for self-resetting faults
    // a fault seen now turns the stage off in the cycle it reaches the latch
    nxt_cur.power_en = !clear_req && (active == 20'h0) &&
                       (present == 20'h0) &&
                       (cur_ff.hold == 32'h0);

    if (clear_req)
    begin
      nxt_cur.ext = sfm_pkg::SFM_EXT_NONE;
    end
    if (ext_event)
    begin
      nxt_cur.ext = ext_src;
    end

    // a shown latched fault stays until the enable input is cycled
    if (cur_ff.shown == sfm_pkg::CODE_NONE ||
        (shown_gone && (clear_req || shown_self)))
    begin
      nxt_cur.shown = best;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cur_ff <= '{s1: '0, s2: '0, s3: '0, filt: '0, ov: 1'b0,
                  latched: 20'h0, hold: 32'h0, power_en: 1'b0,
                  shown: 5'h00, ext: sfm_pkg::SFM_EXT_NONE};
    end
    else
    begin
      cur_ff <= nxt_cur;
    end
  end

  // ----------------------------------------------------------------
  // led and outputs
  // ----------------------------------------------------------------
  assign blink_bus.code = cur_ff.shown;

  sfm_blink #(
    .ON_CYC(BLINK_ON_CYC),
    .OFF_CYC(BLINK_OFF_CYC),
    .GAP_CYC(BLINK_GAP_CYC)
  ) u_blink (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .blink(blink_bus.gen)
  );

  assign power_stage_en_out = cur_ff.power_en;
  assign fault_active_out = (cur_ff.shown != sfm_pkg::CODE_NONE);
  assign fault_code_out = cur_ff.shown;
  assign extended_fault_code_out = cur_ff.ext;
  assign latched_faults_out = cur_ff.latched;
  assign status_led_out = blink_bus.led;

endmodule : sfm_fault_mgr

// file: rtl/sfm_pkg.sv
// Function
// - any detected fault turns the power output stage off
// - only latched-class fault sources are held in the fault latch
// - status LED blinks as many times as the reported fault code
// - feedback device communication failure reports code 17
// - option card watchdog timeout reports code 18
// - step overflow or following error beyond 128 revs reports 19
// - option card fault reports 20, extended code aux or none
// - non-latched faults re-enable the stage once their cause is gone
// - enable input in disable state, or power cycle, clears latched faults
// - self-resetting faults keep drive off 50 to 100 ms after clearing
// - with several faults active only the highest priority is shown; a shown code is kept until its fault is gone, even if a higher one arrives
// - after clear and enable cycle, show highest fault still present
// - over-voltage clears only below threshold minus hysteresis
package sfm_pkg;

  // ----------------------------------------------------------------
  // fault codes
  // ----------------------------------------------------------------
  localparam int NUM_CODES = 20;
  localparam int CODE_W = 5;
  localparam logic [4:0] CODE_NONE = 5'h00;
  localparam logic [4:0] CODE_ONE = 5'h01;
  localparam logic [4:0] CODE_OVERVOLT = 5'h07;
  localparam logic [4:0] CODE_UNDERVOLT = 5'h08;
  localparam logic [4:0] CODE_FB_COMM = 5'h11;
  localparam logic [4:0] CODE_OPT_WDOG = 5'h12;
  localparam logic [4:0] CODE_POS_ERR = 5'h13;
  localparam logic [4:0] CODE_OPT_CARD = 5'h14;

  // bit i stands for code i+1; codes 7 and 8 reset themselves
  localparam logic [19:0] LATCH_CLASS = 20'hFFF3F;

  // highest priority first
  localparam logic [4:0] PRIO_ORDER [NUM_CODES] = '{
    5'h09, 5'h0A, 5'h0D, 5'h07, 5'h08, 5'h0B, 5'h0C, 5'h0E, 5'h0F, 5'h10,
    5'h11, 5'h12, 5'h13, 5'h14, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06
  };

  // ----------------------------------------------------------------
  // extended fault code
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SFM_EXT_NONE = 2'h0,
    SFM_EXT_STEP_OVF = 2'h1,
    SFM_EXT_POS_OVF = 2'h2,
    SFM_EXT_AUX_FB = 2'h3
  } sfm_ext_t;

  localparam int FE_LIMIT_REVS = 128;

  // ----------------------------------------------------------------
  // pin vector layout
  // ----------------------------------------------------------------
  localparam int PIN_W = 25;
  localparam int PIN_OV_ABOVE = 20;
  localparam int PIN_OV_BELOW = 21;
  localparam int PIN_ENABLE_N = 22;
  localparam int PIN_AUX_FB = 23;
  localparam int PIN_SYNC_LOSS = 24;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int HOLDOFF_MS = 50;
  localparam int HOLDOFF_CYC = HOLDOFF_MS * CYC_PER_MS;
  localparam int BLINK_ON_MS = 250;
  localparam int BLINK_OFF_MS = 250;
  localparam int BLINK_GAP_MS = 1500;
  localparam int BLINK_ON_CYC = BLINK_ON_MS * CYC_PER_MS;
  localparam int BLINK_OFF_CYC = BLINK_OFF_MS * CYC_PER_MS;
  localparam int BLINK_GAP_CYC = BLINK_GAP_MS * CYC_PER_MS;
  localparam int CNT_W = 32;

endpackage : sfm_pkg

// file: verif/sfm_ctrl_model.sv
`timescale 1ns/1ps
module sfm_ctrl_model (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic disable_req_in,
  output logic enable_n_out
);
  // enable is a plain level; a disable spell or a reset clears the latched faults
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      enable_n_out <= 1'b0;
    else
      enable_n_out <= disable_req_in;
  end
endmodule : sfm_ctrl_model

// file: verif/sfm_fault_mgr_monitor.sv
`timescale 1ns/1ps
module sfm_fault_mgr_chk #(
  parameter int FE_W = 16,
  parameter int HOLDOFF_CYC = 20
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [19:0] fault_det_in,
  input wire logic bus_ov_above_in,
  input wire logic bus_ov_below_hyst_in,
  input wire logic enable_n_in,
  input wire logic aux_feedback_fault_in,
  input wire logic controller_sync_loss_in,
  input wire logic step_size_overflow_in,
  input wire logic signed [FE_W-1:0] following_error_in,
  input wire logic power_stage_en_out,
  input wire logic fault_active_out,
  input wire logic [4:0] fault_code_out,
  input wire logic [1:0] extended_fault_code_out,
  input wire logic [19:0] latched_faults_out,
  input wire logic status_led_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  // ----------------------------------------------------------------
  // cycles since a self-resetting cause was last seen at the pins
  // ----------------------------------------------------------------
  // starts at the pins, so it is never later than the design's own count
  int hold_cnt_ff;
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      hold_cnt_ff <= HOLDOFF_CYC;
    else if (bus_ov_above_in || fault_det_in[7])
      hold_cnt_ff <= 0;
    else if (hold_cnt_ff < HOLDOFF_CYC)
      hold_cnt_ff <= hold_cnt_ff + 1;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_fault_off;
    (|latched_faults_out) |-> !power_stage_en_out;
  endproperty
  a_fault_off: assert property (p_fault_off)
    else $error("power stage on with latched fault");
  property p_no_self_latch;
    latched_faults_out[7:6] == 2'h0;
  endproperty
  a_no_self_latch: assert property (p_no_self_latch)
    else $error("self-resetting fault latched");
  property p_latch_short;
    fault_det_in[8] [*8] |-> latched_faults_out[8] && fault_active_out;
  endproperty
  a_latch_short: assert property (p_latch_short)
    else $error("held fault not latched");
  property p_holdoff;
    $rose(power_stage_en_out) |-> hold_cnt_ff >= HOLDOFF_CYC;
  endproperty
  a_holdoff: assert property (p_holdoff)
    else $error("drive back on before holdoff");
  property p_clear;
    (enable_n_in && fault_det_in == 20'h00000 && !aux_feedback_fault_in
      && !controller_sync_loss_in && !step_size_overflow_in) [*8]
      |-> latched_faults_out[17:0] == 18'h00000;
  endproperty
  a_clear: assert property (p_clear)
    else $error("latch not cleared by disable");
  property p_led_on;
    $rose(status_led_out) |-> status_led_out [*4] ##1 !status_led_out;
  endproperty
  a_led_on: assert property (p_led_on)
    else $error("led pulse length wrong");
  property p_ov_off;
    bus_ov_above_in [*8] |-> !power_stage_en_out && fault_active_out;
  endproperty
  a_ov_off: assert property (p_ov_off)
    else $error("power on during over-voltage");
  property p_step_ext;
    step_size_overflow_in |=> extended_fault_code_out == 2'h1
      && latched_faults_out[18];
  endproperty
  a_step_ext: assert property (p_step_ext)
    else $error("step overflow not reported");
  c_code9: cover property (fault_code_out == 5'h09);
  c_ov: cover property (fault_code_out == 5'h07);
  c_led: cover property ($rose(status_led_out));
endmodule : sfm_fault_mgr_chk

bind sfm_fault_mgr sfm_fault_mgr_chk #(.FE_W(FE_W),
  .HOLDOFF_CYC(HOLDOFF_CYC)) u_chk (
  .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
  .fault_det_in(fault_det_in), .bus_ov_above_in(bus_ov_above_in),
  .bus_ov_below_hyst_in(bus_ov_below_hyst_in),
  .enable_n_in(enable_n_in), .aux_feedback_fault_in(aux_feedback_fault_in),
  .controller_sync_loss_in(controller_sync_loss_in),
  .step_size_overflow_in(step_size_overflow_in),
  .following_error_in(following_error_in),
  .power_stage_en_out(power_stage_en_out),
  .fault_active_out(fault_active_out), .fault_code_out(fault_code_out),
  .extended_fault_code_out(extended_fault_code_out),
  .latched_faults_out(latched_faults_out),
  .status_led_out(status_led_out));

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int HOLD = 20;
  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [19:0] fdet = 20'h00000;
  logic ov_hi = 1'b0;
  logic ov_lo = 1'b1;
  logic aux = 1'b0;
  logic sloss = 1'b0;
  logic step = 1'b0;
  logic signed [15:0] fe = 16'h0000;
  logic dis_req = 1'b0;
  logic en_n, pwr, act, led;
  logic [4:0] code;
  logic [1:0] ext;
  logic [19:0] lat;
  int err_total = 0;
  int n_tests = 0;
  always #4 sys_clk_in = ~sys_clk_in;
  sfm_ctrl_model ctrl (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .disable_req_in(dis_req), .enable_n_out(en_n));
  sfm_fault_mgr #(.HOLDOFF_CYC(HOLD), .BLINK_ON_CYC(4), .BLINK_OFF_CYC(4),
    .BLINK_GAP_CYC(10)) dut (.sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in), .fault_det_in(fdet), .bus_ov_above_in(ov_hi),
    .bus_ov_below_hyst_in(ov_lo), .enable_n_in(en_n),
    .aux_feedback_fault_in(aux), .controller_sync_loss_in(sloss),
    .step_size_overflow_in(step), .following_error_in(fe),
    .power_stage_en_out(pwr), .fault_active_out(act), .fault_code_out(code),
    .extended_fault_code_out(ext), .latched_faults_out(lat),
    .status_led_out(led));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic too_long;
    err_total++;
    $display("BAD t=%0t wait ran out", $time);
    end_of_test;
  endtask : too_long
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask : cyc
  task automatic clear_cycle;
    dis_req <= 1'b1;
    cyc(10);
    dis_req <= 1'b0;
    cyc(10);
  endtask : clear_cycle
  task automatic wait_pwr(input int lo, input int hi);
    int n;
    n = 0;
    while (pwr !== 1'b1 && n < hi)
    begin
      cyc(1);
      n++;
    end
    if (n >= hi)
      too_long;
    chk(n >= lo, 1);
  endtask : wait_pwr
  task automatic t_latch;
    fdet[8] <= 1'b1;
    cyc(10);
    chk({pwr, act, code, lat[8]}, {1'b0, 1'b1, 5'h09, 1'b1});
    fdet[8] <= 1'b0;
    cyc(20);
    chk({pwr, lat[8]}, 2'b01);
    clear_cycle;
    chk({lat, code, act}, 26'h0);
    wait_pwr(0, 20);
    $display("latch test done");
  endtask : t_latch
  task automatic src(input int i, input logic v);
    case (i)
      0: fdet[16] <= v;
      1: fdet[17] <= v;
      2: step <= v;
      3: fe <= v ? 16'sd129 : 16'sd0;
      4: aux <= v;
      default: sloss <= v;
    endcase
  endtask : src
  task automatic t_codes;
    logic [4:0] ec [6] = '{5'h11, 5'h12, 5'h13, 5'h13, 5'h14, 5'h14};
    logic [1:0] ee [6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
    for (int i = 0; i < 6; i++)
    begin
      src(i, 1'b1);
      cyc(10);
      chk({code, ext, pwr}, {ec[i], ee[i], 1'b0});
      src(i, 1'b0);
      clear_cycle;
      chk({code, ext}, 7'h00);
    end
    $display("code test done");
  endtask : t_codes
  task automatic t_self;
    ov_hi <= 1'b1;
    ov_lo <= 1'b0;
    cyc(10);
    chk({pwr, code, lat}, {1'b0, 5'h07, 20'h00000});
    ov_hi <= 1'b0;
    cyc(HOLD + 10);
    chk(pwr, 1'b0);
    ov_lo <= 1'b1;
    wait_pwr(HOLD, HOLD + 12);
    fdet[7] <= 1'b1;
    cyc(10);
    chk({pwr, code, lat[7]}, {1'b0, 5'h08, 1'b0});
    fdet[7] <= 1'b0;
    wait_pwr(HOLD, HOLD + 12);
    chk(code, 5'h00);
    $display("self reset test done");
  endtask : t_self
  task automatic t_prio;
    fdet <= 20'h10101;
    cyc(10);
    chk(code, 5'h09);
    fdet[8] <= 1'b0;
    cyc(10);
    chk(code, 5'h09);
    clear_cycle;
    chk(code, 5'h11);
    fdet[16] <= 1'b0;
    clear_cycle;
    chk(code, 5'h01);
    fdet[0] <= 1'b0;
    clear_cycle;
    chk(code, 5'h00);
    $display("priority test done");
  endtask : t_prio
  task automatic t_led;
    int low, rises, n;
    logic prev;
    fdet[2] <= 1'b1;
    cyc(10);
    fdet[2] <= 1'b0;
    low = 0;
    n = 0;
    while (low < 8 && n < 200)
    begin
      cyc(1);
      n++;
      low = led ? 0 : low + 1;
    end
    rises = 0;
    low = 0;
    prev = 1'b0;
    while ((rises == 0 || low < 8) && n < 400)
    begin
      cyc(1);
      n++;
      if (led && !prev)
        rises++;
      prev = led;
      low = led ? 0 : low + 1;
    end
    if (n >= 400)
      too_long;
    chk(rises, 3);
    clear_cycle;
    $display("led test done");
  endtask : t_led
  task automatic t_power_cycle;
    fdet[9] <= 1'b1;
    cyc(10);
    fdet[9] <= 1'b0;
    cyc(4);
    reset_n_in <= 1'b0;
    cyc(6);
    reset_n_in <= 1'b1;
    cyc(12);
    chk({lat, pwr}, 21'h1);
    $display("power cycle test done");
  endtask : t_power_cycle
  initial
  begin
    cyc(6);
    reset_n_in <= 1'b1;
    cyc(12);
    chk(pwr, 1'b1);
    t_latch;
    t_codes;
    t_self;
    t_prio;
    t_led;
    t_power_cycle;
    end_of_test;
  end
endmodule : testbench
